// ==== design/dpw_pkg.sv ====
// Constants and carrier types for the direct pixel write and blend block
package dpw_pkg;
    // ----------------------------------------------------------------
    // Register offsets (byte addresses on the bus)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_DIRECT_CTRL = 8'h00;
    localparam logic [7:0] REG_BLEND = 8'h04;
    localparam logic [7:0] REG_DEPTH_MODE = 8'h08;
    localparam logic [7:0] REG_CONST_DA = 8'h0C;
    localparam logic [31:0] RST_REG = 32'h0000_0000;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int DWC_FMT_LO = 0;
    localparam int DWC_PIPE = 8;
    localparam int DWC_LANE_LO = 9;
    localparam int DWC_WSWAP = 11;
    localparam int DWC_SWZ = 12;
    localparam int DWC_YORG = 13;
    localparam int DWC_WSEL = 14;
    localparam logic [31:0] DWC_MASK = 32'h0000_7F0F;
    localparam int BLD_ENABLE = 4;
    localparam int BLD_CODES_LO = 8;
    localparam int DBM_CMASK = 9;
    localparam int DBM_ZMASK = 10;
    localparam int DBM_ABUF = 18;
    localparam int POS_X_LO = 1;
    localparam int POS_Y_LO = 11;
    localparam logic [9:0] LAST_ROW = 10'h3FF;
    // ----------------------------------------------------------------
    // Write formats
    // ----------------------------------------------------------------
    localparam logic [3:0] FMT_RGB565 = 4'h0;
    localparam logic [3:0] FMT_XRGB1555 = 4'h1;
    localparam logic [3:0] FMT_ARGB1555 = 4'h2;
    localparam logic [3:0] FMT_XRGB8888 = 4'h4;
    localparam logic [3:0] FMT_ARGB8888 = 4'h5;
    localparam logic [3:0] FMT_Z_RGB565 = 4'hC;
    localparam logic [3:0] FMT_Z_XRGB1555 = 4'hD;
    localparam logic [3:0] FMT_Z_ARGB1555 = 4'hE;
    localparam logic [3:0] FMT_Z_Z = 4'hF;
    // ----------------------------------------------------------------
    // Blend factor codes
    // ----------------------------------------------------------------
    localparam logic [3:0] FACTOR_ZERO = 4'h0;
    localparam logic [3:0] FACTOR_SOURCE_ALPHA = 4'h1;
    localparam logic [3:0] FACTOR_OTHER_COLOR = 4'h2;
    localparam logic [3:0] FACTOR_DESTINATION_ALPHA = 4'h3;
    localparam logic [3:0] FACTOR_ONE = 4'h4;
    localparam logic [3:0] FACTOR_INVERSE_SOURCE_ALPHA = 4'h5;
    localparam logic [3:0] FACTOR_INVERSE_OTHER_COLOR = 4'h6;
    localparam logic [3:0] FACTOR_INVERSE_DESTINATION_ALPHA = 4'h7;
    localparam logic [3:0] FACTOR_SPECIAL = 4'hF;
    localparam logic [8:0] FACTOR_UNITY = 9'h100;
    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] dst_a;
        logic [3:0] src_a;
        logic [3:0] dst_rgb;
        logic [3:0] src_rgb;
    } dpw_codes_s;
    typedef struct packed {
        logic [9:0] x;
        logic [9:0] y;
        logic [31:0] color;
        logic [31:0] depth;
        logic [15:0] w;
        logic pair;
        logic pipe;
        logic we_color;
        logic we_depth;
        logic we_alpha;
    } dpw_pix_s;
endpackage : dpw_pkg

// ==== design/dpw_blend.sv ====
// Blend stage combining source and destination colour and alpha
`timescale 1ns/1ps
`default_nettype none
module dpw_blend (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Controls
    input wire logic i_enable,
    input wire dpw_pkg::dpw_codes_s i_codes,
    // Pixel in, ARGB bytes
    input wire logic i_valid,
    input wire logic [31:0] i_src,
    input wire logic [31:0] i_dst,
    input wire logic [23:0] i_unfog,
    // Pixel out
    output logic o_valid,
    output logic [31:0] o_data
);
    import dpw_pkg::*;

    // Maps 8'hFF to exact unity so that one times x keeps x
    function automatic logic [8:0] ext(input logic [7:0] v);
        ext = {1'b0, v} + {8'h00, v[7]};
    endfunction : ext

    function automatic logic [8:0] fac(input logic [3:0] code,
        input logic is_src, input logic [7:0] other,
        input logic [7:0] unf, input logic [7:0] sa,
        input logic [7:0] da);
        logic [8:0] inv_da;
        inv_da = FACTOR_UNITY - ext(da);
        case (code)
            FACTOR_ZERO: fac = 9'h000;
            FACTOR_SOURCE_ALPHA: fac = ext(sa);
            FACTOR_OTHER_COLOR: fac = ext(other);
            FACTOR_DESTINATION_ALPHA: fac = ext(da);
            FACTOR_ONE: fac = FACTOR_UNITY;
            FACTOR_INVERSE_SOURCE_ALPHA: fac = FACTOR_UNITY - ext(sa);
            FACTOR_INVERSE_OTHER_COLOR: fac = FACTOR_UNITY - ext(other);
            FACTOR_INVERSE_DESTINATION_ALPHA: fac = inv_da;
            FACTOR_SPECIAL: begin
                if (is_src) begin
                    fac = (ext(sa) < inv_da) ? ext(sa) : inv_da;
                end else begin
                    fac = ext(unf);
                end
            end
            default: fac = 9'h000;
        endcase
    endfunction : fac

    logic [31:0] next_data;
    genvar ch;
    for (ch = 0; ch < 4; ch++) begin : g_ch
        logic [3:0] sc;
        logic [3:0] dc;
        logic [7:0] s;
        logic [7:0] d;
        logic [7:0] u;
        logic [16:0] ps;
        logic [16:0] pd;
        logic [17:0] sum;
        assign s = i_src[ch*8 +: 8];
        assign d = i_dst[ch*8 +: 8];
        // Alpha lane has no unfogged value of its own, so it takes source
        if (ch == 3) begin : g_a
            assign u = s;
        end else begin : g_c
            assign u = i_unfog[ch*8 +: 8];
        end
        // Alpha lane takes its own pair of codes
        assign sc = (ch == 3) ? i_codes.src_a : i_codes.src_rgb;
        assign dc = (ch == 3) ? i_codes.dst_a : i_codes.dst_rgb;
        // Full-width products: inside a concatenation a product is cut
        // to its widest operand, which would lose the top byte
        assign ps = {9'h000, s} * {8'h00, fac(sc, 1'b1, d, u,
            i_src[31:24], i_dst[31:24])};
        assign pd = {9'h000, d} * {8'h00, fac(dc, 1'b0, s, u,
            i_src[31:24], i_dst[31:24])};
        assign sum = {1'b0, ps} + {1'b0, pd};
        assign next_data[ch*8 +: 8] = !i_enable ? s :
            (sum[17:16] != 2'b00) ? 8'hFF : sum[15:8];
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_valid <= 1'b0;
            o_data <= 32'h0000_0000;
        end else begin
            o_valid <= i_valid;
            o_data <= next_data;
        end
    end

    AST_BLEND_ONE_ZERO: assert property (@(posedge i_clk)
        disable iff (i_rst)
        i_valid && i_enable && i_codes.src_rgb == FACTOR_ONE
        && i_codes.dst_rgb == FACTOR_ZERO
        |=> o_data[23:0] == $past(i_src[23:0]))
        else $error("blend one-zero did not pass source colour");
    AST_ALPHA_ZERO: assert property (@(posedge i_clk)
        disable iff (i_rst)
        i_valid && i_enable && i_codes.src_a == FACTOR_ZERO
        && i_codes.dst_a == FACTOR_ZERO |=> o_data[31:24] == 8'h00)
        else $error("alpha zero factors gave nonzero alpha");
endmodule : dpw_blend
`default_nettype wire

// ==== design/dpw_top.sv ====
// Direct pixel write path, blend stage and their control registers
// --------------------------------------------------------------------
// Behaviour
// - Enabled blend: new colour = source*src factor + old dest*dst factor
// - Alpha blends the same way with its own factor pair
// - Blend register: colour codes in 15:8, alpha codes in 23:16
// - Codes 0-7: zero, src a, colour, dst a, one and inverses
// - Colour code means the other pixel's colour
// - Code 15 as destination factor uses the unfogged source colour
// - Code 15 as source factor uses min(src alpha, 1 - dst alpha)
// - Format field 3:0 decodes 16-bit, 32-bit and depth-paired layouts
// - Pipeline bit set: writes go through the pixel pipeline
// - Pipeline bit clear: write buffers unconditionally, tests bypassed
// - Bypass writes only carried buffers, ignoring colour and depth masks
// - Bypass formats 0,1,2,4,5 write colour only
// - Bypass formats 12-14 write colour and depth
// - Bypass format 15 writes depth only
// - Bypass alpha formats write alpha only if alpha buffer enabled
// - Bypass format 14 drops depth or alpha by alpha buffer enable
// - Lane field 10:9 selects colour lane order
// - Lanes: 0 ARGB, 1 ABGR, 2 RGBA, 3 BGRA
// - Bit 11 swaps the 16-bit halves of each write
// - Bit 12 byte-swizzles each write
// - Swizzle exchanges bytes 3 and 0, and bytes 2 and 1
// - Swizzle, then half swap (not formats 4, 5), then lanes
// - Bit 13 picks Y origin: 0 top, 1 bottom; the code flips bypass writes only
// - Bit 14 picks W: write depth or constant depth-alpha 15:0; the code sets W on pipeline writes only, bypass W is 0
// --------------------------------------------------------------------
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dpw_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    // Direct pixel window writes
    input wire logic i_dw_stb,
    input wire logic [21:0] i_dw_offset,
    input wire logic [31:0] i_dw_data,
    output logic o_dw_valid,
    output dpw_pkg::dpw_pix_s o_dw_pix,
    // Blend stage
    input wire logic i_bl_valid,
    input wire logic [31:0] i_bl_src,
    input wire logic [31:0] i_bl_dst,
    input wire logic [23:0] i_bl_unfog,
    output logic o_bl_valid,
    output logic [31:0] o_bl_data
);
    import dpw_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [31:0] dwc;
    logic [31:0] bld;
    logic [31:0] dbm;
    logic [31:0] cda;
    logic wr;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] sel);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                merge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    endfunction : merge

    // Write lands on the edge that the master sees ack
    assign wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dwc <= RST_REG;
            bld <= RST_REG;
            dbm <= RST_REG;
            cda <= RST_REG;
        end else if (wr) begin
            case (i_wb_adr)
                REG_DIRECT_CTRL:
                    dwc <= merge(dwc, i_wb_dat, i_wb_sel) & DWC_MASK;
                REG_BLEND: bld <= merge(bld, i_wb_dat, i_wb_sel);
                REG_DEPTH_MODE: dbm <= merge(dbm, i_wb_dat, i_wb_sel);
                REG_CONST_DA: cda <= merge(cda, i_wb_dat, i_wb_sel);
                default: dwc <= dwc;
            endcase
        end
    end

    // Unmapped reads answer zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wb_dat <= 32'h0000_0000;
        end else if (i_wb_cyc && i_wb_stb && !o_wb_ack) begin
            case (i_wb_adr)
                REG_DIRECT_CTRL: o_wb_dat <= dwc & DWC_MASK;
                REG_BLEND: o_wb_dat <= bld;
                REG_DEPTH_MODE: o_wb_dat <= dbm;
                REG_CONST_DA: o_wb_dat <= cda;
                default: o_wb_dat <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    logic [3:0] fmt;
    logic [1:0] lane;
    logic pipe;
    logic abuf;
    assign fmt = dwc[DWC_FMT_LO +: 4];
    assign lane = dwc[DWC_LANE_LO +: 2];
    assign pipe = dwc[DWC_PIPE];
    // Colour and depth masks in dbm are left to the pipeline, never here
    assign abuf = dbm[DBM_ABUF];

    // ----------------------------------------------------------------
    // Data reordering
    // ----------------------------------------------------------------
    // 16-bit colour to canonical order; base 0 is 565, else 1555
    function automatic logic [15:0] lane16(input logic [15:0] h,
        input logic is565, input logic [1:0] ln);
        lane16 = h;
        if (is565) begin
            if (ln[0]) begin
                lane16 = {h[4:0], h[10:5], h[15:11]};
            end
        end else begin
            case (ln)
                2'd1: lane16 = {h[15], h[4:0], h[9:5], h[14:10]};
                2'd2: lane16 = {h[0], h[15:1]};
                2'd3: lane16 = {h[0], h[5:1], h[10:6], h[15:11]};
                default: lane16 = h;
            endcase
        end
    endfunction : lane16

    function automatic logic [31:0] lane32(input logic [31:0] d,
        input logic [1:0] ln);
        case (ln)
            2'd1: lane32 = {d[31:24], d[7:0], d[15:8], d[23:16]};
            2'd2: lane32 = {d[7:0], d[31:8]};
            2'd3: lane32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
            default: lane32 = d;
        endcase
    endfunction : lane32

    logic is32;
    logic is565;
    logic [31:0] swz;
    logic [31:0] swp;
    assign is32 = (fmt == FMT_XRGB8888) || (fmt == FMT_ARGB8888);
    assign is565 = (fmt == FMT_RGB565) || (fmt == FMT_Z_RGB565);
    assign swz = dwc[DWC_SWZ] ? {i_dw_data[7:0], i_dw_data[15:8],
        i_dw_data[23:16], i_dw_data[31:24]} : i_dw_data;
    // Swap follows swizzle and never touches 32-bit formats
    assign swp = (dwc[DWC_WSWAP] && !is32) ?
        {swz[15:0], swz[31:16]} : swz;

    // ----------------------------------------------------------------
    // Pixel assembly
    // ----------------------------------------------------------------
    dpw_pix_s next_pix;
    logic next_valid;
    logic [9:0] y_raw;

    assign y_raw = i_dw_offset[POS_Y_LO +: 10];

    always_comb begin
        next_pix = '0;
        next_valid = i_dw_stb;
        next_pix.x = i_dw_offset[POS_X_LO +: 10];
        // Y flip only applies to bypassed writes
        next_pix.y = (!pipe && dwc[DWC_YORG]) ?
            LAST_ROW - y_raw : y_raw;
        next_pix.pipe = pipe;
        case (fmt)
            FMT_RGB565, FMT_XRGB1555, FMT_ARGB1555: begin
                next_pix.color = {lane16(swp[31:16], is565, lane),
                                  lane16(swp[15:0], is565, lane)};
                next_pix.depth = {16'h0000, cda[15:0]};
                next_pix.pair = 1'b1;
                next_pix.we_color = !pipe;
                next_pix.we_alpha = !pipe && fmt == FMT_ARGB1555
                    && abuf;
            end
            FMT_XRGB8888, FMT_ARGB8888: begin
                next_pix.color = lane32(swp, lane);
                next_pix.depth = {16'h0000, cda[15:0]};
                next_pix.we_color = !pipe;
                next_pix.we_alpha = !pipe && fmt == FMT_ARGB8888
                    && abuf;
            end
            FMT_Z_RGB565, FMT_Z_XRGB1555, FMT_Z_ARGB1555: begin
                next_pix.color = {16'h0000,
                                  lane16(swp[15:0], is565, lane)};
                next_pix.depth = {16'h0000, swp[31:16]};
                next_pix.we_color = !pipe;
                if (fmt == FMT_Z_ARGB1555) begin
                    next_pix.we_depth = !pipe && !abuf;
                    next_pix.we_alpha = !pipe && abuf;
                end else begin
                    next_pix.we_depth = !pipe;
                end
            end
            FMT_Z_Z: begin
                next_pix.depth = swp;
                next_pix.pair = 1'b1;
                next_pix.we_depth = !pipe;
            end
            default: begin
                // Reserved format: the write is dropped whole
                next_valid = 1'b0;
            end
        endcase
        // Bypass writes ignore the masks in dbm entirely
        if (pipe) begin
            next_pix.w = dwc[DWC_WSEL] ? cda[15:0]
                                       : next_pix.depth[15:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_dw_valid <= 1'b0;
            o_dw_pix <= '0;
        end else begin
            o_dw_valid <= next_valid;
            o_dw_pix <= next_pix;
        end
    end

    // ----------------------------------------------------------------
    // Blend stage
    // ----------------------------------------------------------------
    dpw_codes_s codes;
    assign codes = bld[BLD_CODES_LO +: 16];

    dpw_blend u_blend (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_enable(bld[BLD_ENABLE]),
        .i_codes(codes),
        .i_valid(i_bl_valid),
        .i_src(i_bl_src),
        .i_dst(i_bl_dst),
        .i_unfog(i_bl_unfog),
        .o_valid(o_bl_valid),
        .o_data(o_bl_data)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_bypass(logic [3:0] f);
        i_dw_stb && !pipe && fmt == f;
    endsequence
    sequence s_wb_read(logic [7:0] a);
        i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack && i_wb_adr == a
        ##1 o_wb_ack;
    endsequence

    AST_WB_ACK: assert property (
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
        else $error("ack not a single cycle after request");
    AST_CTRL_RESERVED_ZERO: assert property (
        s_wb_read(REG_DIRECT_CTRL)
        |-> (o_wb_dat & ~DWC_MASK) == 32'h0000_0000)
        else $error("reserved control bits read nonzero");

    // Pixel checks look one cycle after the strobe, while the registered
    // pixel still holds the write that caused it
    AST_LOW_FMT_COLOR_ONLY: assert property (
        (s_bypass(FMT_RGB565) or s_bypass(FMT_XRGB8888))
        |=> o_dw_valid && o_dw_pix.we_color && !o_dw_pix.we_depth)
        else $error("colour-only format touched depth");
    AST_Z_COLOR_BOTH: assert property (
        s_bypass(FMT_Z_RGB565)
        |=> o_dw_pix.we_color && o_dw_pix.we_depth)
        else $error("depth-colour format missed a buffer");
    AST_ZZ_DEPTH_ONLY: assert property (
        s_bypass(FMT_Z_Z)
        |=> o_dw_pix.we_depth && !o_dw_pix.we_color
        && o_dw_pix.depth == $past(swp))
        else $error("two-depth format wrote colour");
    AST_FMT14_SPLIT: assert property (
        s_bypass(FMT_Z_ARGB1555)
        |=> o_dw_pix.we_depth != o_dw_pix.we_alpha
        && o_dw_pix.we_alpha == $past(abuf))
        else $error("format 14 kept the wrong component");
    AST_SWIZZLE: assert property (
        s_bypass(FMT_ARGB8888) and (dwc[DWC_SWZ] && lane == 2'd0)
        |=> o_dw_pix.color ==
        {$past(i_dw_data[7:0]), $past(i_dw_data[15:8]),
         $past(i_dw_data[23:16]), $past(i_dw_data[31:24])})
        else $error("swizzle bytes misplaced");
    AST_LANE_ABGR: assert property (
        s_bypass(FMT_ARGB8888) and (lane == 2'd1 && !dwc[DWC_SWZ])
        |=> o_dw_pix.color ==
        {$past(i_dw_data[31:24]), $past(i_dw_data[7:0]),
         $past(i_dw_data[15:8]), $past(i_dw_data[23:16])})
        else $error("ABGR lanes not reordered");
    AST_RESERVED_FMT_DROP: assert property (
        i_dw_stb && fmt == 4'h3 |=> !o_dw_valid)
        else $error("reserved format produced a pixel");
    AST_Y_ORIGIN: assert property (
        i_dw_stb && !pipe && dwc[DWC_YORG]
        |=> o_dw_pix.y == LAST_ROW - $past(y_raw))
        else $error("bottom origin row not flipped");

    AST_PIPE_NO_DIRECT: assert property (
        i_dw_stb && pipe
        |=> o_dw_pix.pipe && !o_dw_pix.we_color && !o_dw_pix.we_depth)
        else $error("pipeline write went straight to buffers");
    AST_WSEL_CONST: assert property (
        i_dw_stb && pipe && dwc[DWC_WSEL]
        |=> o_dw_pix.w == $past(cda[15:0]))
        else $error("W not taken from constant register");
endmodule : dpw_top
`default_nettype wire

// ==== test/dpw_host_model.sv ====
// Host model issuing direct pixel window writes
`timescale 1ns/1ps
`default_nettype none
module dpw_host_model (
    // Clock
    input wire logic i_clk,
    // Window write
    output logic o_stb,
    output logic [21:0] o_offset,
    output logic [31:0] o_data
);
    initial begin
        o_stb = 1'b0;
        o_offset = 22'h000000;
        o_data = 32'h00000000;
    end
    // One write; the window offset encodes x and y
    task automatic put(input logic [9:0] x, input logic [9:0] y,
                       input logic [31:0] d);
        @(posedge i_clk);
        o_stb <= 1'b1;
        o_offset <= {1'b0, y, x, 1'b0};
        o_data <= d;
        @(posedge i_clk);
        // Released data shows its inverse so stale bytes never match
        o_stb <= 1'b0;
        o_data <= ~d;
        #1;
    endtask : put
endmodule : dpw_host_model
`default_nettype wire

// ==== test/dpw_top_tb.sv ====
// Self-checking bench for the direct pixel write and blend block
`timescale 1ns/1ps
`default_nettype none
module dpw_top_tb;
    import dpw_pkg::*;
    logic i_clk, i_rst, cyc, stb, we, ack, dw_stb, dw_valid;
    logic bl_valid, bl_ovalid;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, ddat, bl_src, bl_dst, bl_data, rd;
    logic [21:0] off;
    logic [23:0] bl_unfog;
    dpw_pix_s pix;
    int num_errors = 0;
    int tests_run = 0;
    logic [15:0] ctl [10] = '{16'h0000, 16'h0004, 16'h000C, 16'h000F,
        16'h0005, 16'h000E, 16'h000E, 16'h0003, 16'h0100, 16'h0002};
    logic ab [10] = '{0, 0, 0, 0, 1, 1, 0, 0, 0, 0};
    logic [4:0] fl [10] = '{5'h14, 5'h14, 5'h16, 5'h12, 5'h15, 5'h15,
        5'h16, 5'h00, 5'h18, 5'h14};
    dpw_top i_dpw_top (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
        .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
        .i_dw_stb(dw_stb), .i_dw_offset(off), .i_dw_data(ddat),
        .o_dw_valid(dw_valid), .o_dw_pix(pix), .i_bl_valid(bl_valid),
        .i_bl_src(bl_src), .i_bl_dst(bl_dst), .i_bl_unfog(bl_unfog),
        .o_bl_valid(bl_ovalid), .o_bl_data(bl_data));
    dpw_host_model i_dpw_host_model (.i_clk(i_clk), .o_stb(dw_stb),
        .o_offset(off), .o_data(ddat));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // Classic single cycle; the slave sets the pace, a bound cuts hangs
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge i_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge i_clk);
            if (ack === 1'b1) break;
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 20) begin
            num_errors++;
            give_verdict();
        end
    endtask : wb
    task automatic blend(input logic [31:0] r, input logic [31:0] s,
                         input logic [31:0] d, input logic [31:0] e);
        wb(1'b1, REG_BLEND, r);
        @(posedge i_clk);
        bl_valid <= 1'b1;
        bl_src <= s;
        bl_dst <= d;
        @(posedge i_clk);
        bl_valid <= 1'b0;
        #1;
        check("blend", {bl_ovalid, bl_data}, {1'b1, e});
    endtask : blend
    task automatic dw(input logic [31:0] c, input logic [9:0] y,
                      input logic [31:0] d);
        wb(1'b1, REG_DIRECT_CTRL, c);
        i_dpw_top_host_put(y, d);
    endtask : dw
    task automatic i_dpw_top_host_put(input logic [9:0] y,
                                      input logic [31:0] d);
        i_dpw_host_model.put(10'h007, y, d);
    endtask : i_dpw_top_host_put
    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    initial begin
        {i_rst, cyc, stb, we, bl_valid} = 5'b10000;
        {adr, wdat, bl_src, bl_dst} = '0;
        bl_unfog = 24'hFFFFFF;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int a = 0; a < 20; a += 4) begin
            wb(1'b0, 8'(a), 32'h0);
            check("reset", rd, RST_REG);
        end
        wb(1'b1, REG_DIRECT_CTRL, 32'hFFFFFFFF);
        wb(1'b0, REG_DIRECT_CTRL, 32'h0);
        check("ctrl", rd, DWC_MASK);
        blend(32'h0040_0410, 32'h1122_3344, 32'h5566_7788,
            32'h5522_3344);
        blend(32'h0044_4410, 32'h8080_8080, 32'h9090_9090,
            32'hFFFF_FFFF);
        blend(32'h0000_2010, 32'h00FF_FFFF, 32'h0012_3456,
            32'h0012_3456);
        blend(32'h0000_F010, 32'h0000_0000, 32'h0012_3456,
            32'h0012_3456);
        blend(32'h0000_0F10, 32'hFFFF_FFFF, 32'hC000_0000,
            32'h003E_3E3E);
        blend(32'h0000_0000, 32'h1122_3344, 32'h0, 32'h1122_3344);
        blend(32'h0073_5110, 32'h8040_2010, 32'h40C0_6030,
            32'h507F_3F1F);
        blend(32'h0000_8610, 32'h00FF_FFFF, 32'h0000_80FF,
            32'h00FF_7E00);
        for (int i = 0; i < 10; i++) begin
            wb(1'b1, REG_DEPTH_MODE, {13'h0, ab[i], 18'h00600});
            dw({16'h0, ctl[i]}, 10'h005, 32'h1234_5678);
            if (fl[i][4]) begin
                check("flags", {dw_valid, pix.pipe}, fl[i][4:3]);
                check("we", {pix.we_color, pix.we_depth},
                    fl[i][2:1]);
                check("alpha", pix.we_alpha, fl[i][0]);
            end else begin
                check("valid", dw_valid, 1'b0);
            end
        end
        dw(32'h1800, 10'h005, 32'h1122_3344);
        check("swap", pix.color, 32'h2211_4433);
        dw(32'h1805, 10'h005, 32'h1122_3344);
        check("noswap", pix.color, 32'h4433_2211);
        dw(32'h0205, 10'h005, 32'h1122_3344);
        check("lane", pix.color, 32'h1144_3322);
        dw(32'h2000, 10'h005, 32'h0);
        check("xy", {pix.x, pix.y}, {10'h007, 10'h3FA});
        wb(1'b1, REG_CONST_DA, 32'hABCD_1234);
        dw(32'h410C, 10'h005, 32'h5566_7788);
        check("wconst", pix.w, 16'h1234);
        dw(32'h010C, 10'h005, 32'h5566_7788);
        check("wdepth", pix.w, 16'h5566);
        check("depth", pix.depth, 32'h0000_5566);
        give_verdict();
    end
endmodule : dpw_top_tb
`default_nettype wire
